// file: inc/core_pll_pkg.sv
// Purpose: shared constants and types for the core pll lock and idle control block
// Assumes: axi4-lite register access, 32-bit data, one aligned word per register
// Notes:   the autoidle field takes 0 for manual lock, 1 or 5 for automatic modes
package core_pll_pkg;
  // register byte offsets
  localparam logic [3:0] ADDR_AUTOIDLE   = 4'h0;  // pll_autoidle_reg
  localparam logic [3:0] ADDR_RSTCTRL    = 4'h4;  // reset_control_reg
  localparam logic [3:0] ADDR_CLKCFG     = 4'h8;  // post divider and bypass clock choice
  localparam logic [3:0] ADDR_STATUS     = 4'hc;  // read-only lock state
  // autoidle field encodings
  localparam logic [2:0] AUTO_MANUAL     = 3'h0;
  localparam logic [2:0] AUTO_LOCK_A     = 3'h1;
  localparam logic [2:0] AUTO_LOCK_B     = 3'h5;
  // field positions
  localparam int         AUTOIDLE_MSB    = 2;
  localparam int         COLD_RESET_BIT  = 2;
  localparam int         POST_DIV_MSB    = 4;
  localparam int         DIV2_BIT        = 8;
  localparam int         ST_LOCK_BIT     = 0;
  localparam int         ST_DETECT_BIT   = 1;
  localparam int         ST_SRC_LSB      = 2;
  localparam int         ST_SRC_MSB      = 3;
  localparam int         ST_IDLE_BIT     = 4;
  // reset value, lock settle count and bus response codes
  localparam logic [4:0] POST_DIV_RESET  = 5'h01;
  localparam logic [1:0] SETTLE_CYCLES   = 2'h2;  // consecutive lock-detect samples
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  typedef enum {st_relock, st_locked, st_bypass} pll_state_t;
  typedef enum logic [1:0] {l3_from_pll, l3_from_sys, l3_from_sys_div2} l3_src_t;

  typedef struct packed {
    logic [2:0] autoidle;     // pll automatic control mode
    logic [4:0] post_div;     // pll post divider setting
    logic       bypass_div2;  // bypass l3 source: sys clock halved
  } cfg_t;
endpackage

// file: hdl/core_pll_lock_idle_control.sv
// Purpose: core pll lock tracking, relock after cold reset, isolated lock flag, sdram idle hold-off
// Assumes: all inputs synchronous to aclk; lock detector and power manager are plain logic
// Notes:   registers over axi4-lite; status word reflects live lock state
// Function
// - autoidle value 0 means manual lock; values 1 and 5 mean automatic modes.
// - writing cold-reset bit 2 of reset_control_reg forces a full pll relock.
// - during relock, l3 clock comes from system clock or system clock halved.
// - lock flag crosses to power manager through a latching isolation cell.
// - power manager stops pll input clock when it sees unlocked during sleep.
// - waking from retention or off in automatic mode needs a fresh lock sequence.
// - sdram idle request stays asserted until the lock state is set.
// - wake event during bypass never yields a false locked report.
// - manual lock mode keeps the pll locked once it has locked, until a cold reset forces a relock.
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module core_pll_lock_idle_control
  import core_pll_pkg::*;
(
  input  wire logic        aclk,                    // system clock, 10 MHz
  input  wire logic        aresetn,                 // synchronous reset, active low
  input  wire logic [3:0]  s_axi_awaddr,            // write address
  input  wire logic        s_axi_awvalid,           // write address valid
  output logic             s_axi_awready,           // write address ready
  input  wire logic [31:0] s_axi_wdata,             // write data
  input  wire logic [3:0]  s_axi_wstrb,             // write byte enables
  input  wire logic        s_axi_wvalid,            // write data valid
  output logic             s_axi_wready,            // write data ready
  output logic [1:0]       s_axi_bresp,             // write response
  output logic             s_axi_bvalid,            // write response valid
  input  wire logic        s_axi_bready,            // write response ready
  input  wire logic [3:0]  s_axi_araddr,            // read address
  input  wire logic        s_axi_arvalid,           // read address valid
  output logic             s_axi_arready,           // read address ready
  output logic [31:0]      s_axi_rdata,             // read data
  output logic [1:0]       s_axi_rresp,             // read response
  output logic             s_axi_rvalid,            // read data valid
  input  wire logic        s_axi_rready,            // read data ready
  input  wire logic        pll_lock_detect,         // raw analog lock detector
  input  wire logic        core_sleep_req,          // core going to retention or off
  input  wire logic        internal_wake_event,     // wake from retention or off
  input  wire logic        iso_enable,              // domain isolation active
  input  wire logic        sdram_idle_need,         // power manager wants sdram idle
  output logic             core_pll_lock_flag,      // lock state, clock manager side
  output logic             iso_lock_flag,           // lock state seen by power manager
  output logic             pll_input_clk_en,        // pll reference clock enable
  output logic             sdram_ctl_idle_request,  // hold sdram controller in idle
  output l3_src_t          l3_src,                  // l3 clock source select
  output logic [4:0]       pll_post_divider         // post divider to the pll
);

  // bus state
  logic        aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [3:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0]  bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  cfg_t        cfg, next_cfg;
  logic        commit, cold_req, auto_mode;
  logic [31:0] status_word;

  // pll state
  pll_state_t  state, next_state;
  logic [1:0]  settle_cnt, next_settle_cnt;
  logic        next_lock_flag, next_iso_flag, next_idle_req;
  l3_src_t     next_l3_src;

  assign s_axi_awready = !aw_hold;
  assign s_axi_wready  = !w_hold;
  assign s_axi_arready = !rvalid;  // one read in flight at a time
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;
  assign commit        = aw_hold && w_hold && !bvalid;
  assign cold_req      = commit && (aw_addr == ADDR_RSTCTRL) && w_strb[0] && w_data[COLD_RESET_BIT];
  assign auto_mode     = (cfg.autoidle == AUTO_LOCK_A) || (cfg.autoidle == AUTO_LOCK_B);
  assign pll_post_divider = cfg.post_div;

  // status readback, unused bits read as zero
  always_comb begin
    status_word = '0;
    status_word[ST_LOCK_BIT]            = core_pll_lock_flag;
    status_word[ST_DETECT_BIT]          = pll_lock_detect;
    status_word[ST_SRC_MSB:ST_SRC_LSB]  = l3_src;
    status_word[ST_IDLE_BIT]            = sdram_ctl_idle_request;
  end

  // axi4-lite slave: address and data held separately, committed together
  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold  = w_hold;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    next_cfg     = cfg;
    if (s_axi_awvalid && !aw_hold) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (commit) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      unique case (aw_addr)
        ADDR_AUTOIDLE: begin
          if (w_strb[0]) next_cfg.autoidle = w_data[AUTOIDLE_MSB:0];
        end
        ADDR_CLKCFG: begin
          if (w_strb[0]) next_cfg.post_div = w_data[POST_DIV_MSB:0];
          if (w_strb[1]) next_cfg.bypass_div2 = w_data[DIV2_BIT];
        end
        ADDR_RSTCTRL: ;  // cold-reset bit is self-clearing
        ADDR_STATUS:  ;  // read-only, write ignored
        default: next_bresp = RESP_SLVERR;
      endcase
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_AUTOIDLE: next_rdata = {29'h0, cfg.autoidle};
        ADDR_RSTCTRL:  next_rdata = 32'h0;
        ADDR_CLKCFG:   next_rdata = {23'h0, cfg.bypass_div2, 3'h0, cfg.post_div};
        ADDR_STATUS:   next_rdata = status_word;
        default: begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      aw_addr <= 4'h0;
      w_hold  <= 1'b0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= RESP_OKAY;
      rdata   <= 32'h0;
      cfg     <= '{autoidle: AUTO_MANUAL, post_div: POST_DIV_RESET, bypass_div2: 1'b0};
    end else begin
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold  <= next_w_hold;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
      cfg     <= next_cfg;
    end
  end

  // pll lock control: confirmed lock needs consecutive detector samples, so a
  // glitch on the detector around the wake from bypass cannot report lock early
  always_comb begin
    next_state      = state;
    next_settle_cnt = settle_cnt;
    unique case (state)
      st_relock: begin
        if (pll_lock_detect) begin
          next_settle_cnt = settle_cnt + 2'h1;
          if (next_settle_cnt == SETTLE_CYCLES) next_state = st_locked;
        end else begin
          next_settle_cnt = 2'h0;
        end
      end
      st_locked: begin
        // manual mode never enters bypass, only automatic modes do
        if (auto_mode && core_sleep_req) next_state = st_bypass;
        else if (!pll_lock_detect && auto_mode) next_state = st_relock;
      end
      st_bypass: begin
        next_settle_cnt = 2'h0;  // detector ignored here
        if (internal_wake_event) next_state = st_relock;
      end
    endcase
    if (cold_req) begin
      next_state      = st_relock;
      next_settle_cnt = 2'h0;
    end
    if (next_state != st_relock) next_settle_cnt = 2'h0;
    next_lock_flag = (next_state == st_locked);
    next_idle_req  = !next_lock_flag || sdram_idle_need;
    // bypass source while not locked
    if (next_lock_flag) next_l3_src = l3_from_pll;
    else if (cfg.bypass_div2) next_l3_src = l3_from_sys_div2;
    else next_l3_src = l3_from_sys;
    // latching isolation: value frozen while isolation is on
    next_iso_flag = iso_enable ? iso_lock_flag : next_lock_flag;
  end

  // reference clock stops only when the isolated flag reads unlocked in sleep
  assign pll_input_clk_en = !(core_sleep_req && !iso_lock_flag);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state                  <= st_relock;
      settle_cnt             <= 2'h0;
      core_pll_lock_flag     <= 1'b0;
      iso_lock_flag          <= 1'b0;
      sdram_ctl_idle_request <= 1'b1;
      l3_src                 <= l3_from_sys;
    end else begin
      state                  <= next_state;
      settle_cnt             <= next_settle_cnt;
      core_pll_lock_flag     <= next_lock_flag;
      iso_lock_flag          <= next_iso_flag;
      sdram_ctl_idle_request <= next_idle_req;
      l3_src                 <= next_l3_src;
    end
  end

  sequence cold_write_s;
    cold_req;
  endsequence

  sequence relock_s;
    (state == st_relock) && !core_pll_lock_flag;
  endsequence

  idle_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !core_pll_lock_flag |-> sdram_ctl_idle_request) else $error("sdram idle released before lock");
  cold_relock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cold_write_s |=> relock_s) else $error("cold reset did not force relock");
  bypass_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !core_pll_lock_flag |-> (l3_src != l3_from_pll)) else $error("l3 on pll clock while unlocked");
  iso_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(iso_enable) && iso_enable |-> $stable(iso_lock_flag)) else $error("isolated flag moved");
  // transparent isolation must pass an unlocked state through, so the reference stops in sleep
  clk_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    core_sleep_req && !$past(iso_enable) && !core_pll_lock_flag |-> !pll_input_clk_en)
    else $error("pll input clock not stopped");
  wake_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == st_bypass) && internal_wake_event && !cold_req |=> relock_s ##1 !core_pll_lock_flag)
    else $error("wake reported lock without relock");
  true_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(core_pll_lock_flag) |-> $past(pll_lock_detect) && $past(pll_lock_detect, 2))
    else $error("lock reported without settled detector");
  manual_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == st_locked) && !auto_mode && !cold_req |=> core_pll_lock_flag) else $error("manual mode lost lock");
  auto_bypass_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == st_locked) ##1 (state == st_bypass) |-> $past(auto_mode)) else $error("bypass in manual mode");
  bypass_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == st_bypass) |-> !core_pll_lock_flag) else $error("lock flag high in bypass");

endmodule

// file: testbench/core_pll_far_side_model.sv
// Purpose: far-side model, power manager levels and a pll lock detector
// Assumes: bench commands are levels sampled on aclk
// Notes:   detector forgets all progress when the reference stops, like a real loop
`timescale 1ns/100ps
module core_pll_far_side_model #(
  parameter int LOCK_DELAY = 4  // running reference cycles before detect
) (
  input  wire logic       aclk,             // system clock
  input  wire logic       aresetn,          // sync reset, active low
  input  wire logic       clk_en,           // pll reference enable from the block
  input  wire logic       hold_unlock,      // keep the detector low
  input  wire logic [3:0] cmd,              // need, iso, wake, sleep
  output logic            pll_lock_detect,  // lock detector level
  output logic [3:0]      pm                // need, iso, wake, sleep to the block
);
  int cnt;
  // detector counts only while the reference runs
  always_ff @(posedge aclk) begin
    if (!aresetn || !clk_en || hold_unlock) begin
      cnt <= 0;
      pll_lock_detect <= 1'b0;
    end else begin
      if (cnt < LOCK_DELAY) cnt <= cnt + 1;
      pll_lock_detect <= (cnt == LOCK_DELAY);
    end
    pm <= aresetn ? cmd : 4'h0;
  end
endmodule

// file: testbench/core_pll_lock_idle_control_tb.sv
// Purpose: register-level bench for the core pll lock and idle control block
// Assumes: axi4-lite master tasks, far-side model drives the power manager levels
// Notes:   inputs change by non-blocking assignment at the rising edge
`timescale 1ns/100ps
module core_pll_lock_idle_control_tb;
  import core_pll_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hold_unlock;
  logic [3:0]  awaddr, araddr, wstrb, cmd, pm;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, resp;
  logic        awready, wready, bvalid, arready, rvalid, lock_flag, iso_flag, clk_en, idle_req, detect;
  logic [4:0]  post_div;
  l3_src_t     l3;
  int          failures, comparisons;

  always #50 aclk = ~aclk;

  core_pll_lock_idle_control DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pll_lock_detect(detect), .core_sleep_req(pm[0]),
    .internal_wake_event(pm[1]), .iso_enable(pm[2]), .sdram_idle_need(pm[3]), .core_pll_lock_flag(lock_flag),
    .iso_lock_flag(iso_flag), .pll_input_clk_en(clk_en), .sdram_ctl_idle_request(idle_req), .l3_src(l3),
    .pll_post_divider(post_div));

  core_pll_far_side_model far (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .hold_unlock(hold_unlock),
    .cmd(cmd), .pll_lock_detect(detect), .pm(pm));

  task report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one write: address and data offered together, each released when taken
  task wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 40);
    resp = bresp;
    bready <= 1'b0;
    if (n >= 40) begin
      failures++;
      report_and_stop();
    end
  endtask

  // one read, compared against the expected word
  task rdchk(input logic [3:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 40);
    chk("rdata", rdata, exp);
    chk("rresp", rresp, (a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR);
    rready <= 1'b0;
    if (n >= 40) begin
      failures++;
      report_and_stop();
    end
  endtask

  // bounded wait for the lock flag to reach a level
  task wait_lock(input logic v);
    int n;
    n = 0;
    while (lock_flag !== v && n < 80) begin
      @(negedge aclk);
      n++;
    end
    chk("lock_flag", lock_flag, v);
    if (n >= 80) report_and_stop();
  endtask

  // while unlocked the sdram stays idle and l3 never comes from the pll
  always @(negedge aclk) begin
    if (aresetn === 1'b1 && lock_flag === 1'b0) begin
      chk("idle_hold", idle_req, 1'b1);
      chk("l3_not_pll", l3 != l3_from_pll, 1'b1);
    end
  end

  initial begin
    aclk = 0;
    aresetn = 0;
    {awvalid, wvalid, bready, arvalid, rready, hold_unlock} = '0;
    {awaddr, araddr, cmd, wdata} = '0;
    wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("lock_rst", lock_flag, 1'b0);
    chk("l3_rst", l3, l3_from_sys);
    chk("div_rst", post_div, POST_DIV_RESET);
    rdchk(ADDR_AUTOIDLE, 32'h0);
    rdchk(ADDR_CLKCFG, 32'h1);
    // unmapped offset: error response, no register touched
    wr(4'h2, 32'h5);
    chk("bresp_bad", resp, RESP_SLVERR);
    rdchk(4'h2, 32'h0);
    rdchk(ADDR_AUTOIDLE, 32'h0);
    wait_lock(1'b1);
    chk("l3_pll", l3, l3_from_pll);
    rdchk(ADDR_STATUS, 32'h3);
    // manual mode keeps lock with the detector down
    @(posedge aclk);
    hold_unlock <= 1'b1;
    repeat (6) @(negedge aclk);
    chk("manual_lock", lock_flag, 1'b1);
    chk("manual_idle", idle_req, 1'b0);
    @(posedge aclk);
    hold_unlock <= 1'b0;
    cmd <= 4'h8;
    repeat (3) @(negedge aclk);
    chk("idle_need", idle_req, 1'b1);
    @(posedge aclk);
    cmd <= 4'h0;
    // cold reset with the halved bypass clock chosen
    wr(ADDR_CLKCFG, 32'h101);
    wr(ADDR_RSTCTRL, 32'h4);
    @(negedge aclk);
    chk("cold_lock", lock_flag, 1'b0);
    chk("cold_l3", l3, l3_from_sys_div2);
    chk("bresp", resp, RESP_OKAY);
    rdchk(ADDR_RSTCTRL, 32'h0);
    wait_lock(1'b1);
    // sleep and wake in both automatic modes
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CLKCFG, 32'h102);
      chk("div_sleep", post_div, 5'h02);
      wr(ADDR_AUTOIDLE, {29'h0, (i == 0) ? AUTO_LOCK_A : AUTO_LOCK_B});
      // automatic mode drops lock when the detector falls, then relocks
      @(posedge aclk);
      hold_unlock <= 1'b1;
      repeat (3) @(negedge aclk);
      chk("auto_loss", lock_flag, 1'b0);
      @(posedge aclk);
      hold_unlock <= 1'b0;
      wait_lock(1'b1);
      @(posedge aclk);
      cmd <= 4'h5;
      repeat (3) @(negedge aclk);
      chk("auto_bypass", lock_flag, 1'b0);
      chk("iso_latched", iso_flag, 1'b1);
      chk("ref_kept", clk_en, 1'b1);
      @(posedge aclk);
      cmd <= 4'h1;
      repeat (3) @(negedge aclk);
      chk("iso_follow", iso_flag, 1'b0);
      chk("ref_stop", clk_en, 1'b0);
      @(posedge aclk);
      cmd <= 4'h2;
      @(posedge aclk);
      cmd <= 4'h0;
      repeat (3) @(negedge aclk);
      chk("wake_nolock", lock_flag, 1'b0);
      wait_lock(1'b1);
      wr(ADDR_AUTOIDLE, 32'h0);
      wr(ADDR_CLKCFG, 32'h101);
      chk("div_back", post_div, 5'h01);
    end
    report_and_stop();
  end
endmodule
